// *** src/smart_fan_tach_capture.sv ***
// smart fan tach capture: pwm generation, period measurement and wishbone registers
//
// Summary of operation
// - smart cycle start aligns both pwm active phases
// - smart cycle holds pwm active, at most 50 ms
// - no full period in window gives saturated result
// - first full period count is stored
// - smart mode: one period only reports doubled stored count
// - two periods load value and end extension
// - normal mode accuracy bits read 00
// - smart accuracy 11 for two, 10 for one
// - smart mode: fewer than one period gives accuracy 10
// - smart mode scans four inputs within 4 s
// - single enabled edge type used exclusively
// - both enabled: first arriving edge type used
// - normal mode counts two periods, 1 s scan
// - value above low-speed limit flags error
`timescale 1ns/1ps
module smart_fan_tach_capture
  import fan_tach_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int EXT_WINDOW = EXT_WINDOW_CYC,
  parameter int SMART_SLOT = SMART_SLOT_CYC,
  parameter int NORMAL_SLOT = NORMAL_SLOT_CYC,
  parameter int NORMAL_WINDOW = NORMAL_WINDOW_CYC,
  parameter int TICK_DIV = TICK_DIV_CYC,
  parameter int PWM_PRESCALE = PWM_PRESCALE_CYC
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [ADR_W-1:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [3:0] tach_i, // fan tach inputs
  output logic [1:0] pwm_o, // fan pwm outputs, active high
  output logic [3:0] tach_err_o // per fan low-speed error
);

  ////////////////////////////////////////////////////////////////////////////
  // whole state of the block
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic smart_en;
    logic [1:0] edge_sel;
    logic [1:0][7:0] duty;
    logic [3:0][9:0] limit;
    logic [3:0][9:0] value;
    logic [3:0] err;
    seq_state_t state;
    logic [1:0] ch;
    logic [31:0] slot_cnt;
    logic [31:0] win_cnt;
    logic [31:0] tick_cnt;
    logic [7:0] cnt;
    logic [7:0] cnt1;
    logic [1:0] edges;
    logic locked;
    logic lock_fall;
    logic [3:0] tach_prev;
    logic [31:0] pwm_pre;
    logic [7:0] pwm_cnt;
    logic [1:0] pwm_q;
    logic ext;
  } state_t;

  state_t s;
  state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic access;
    logic [31:0] wmask;
    logic [31:0] wr_word;
    logic [31:0] rd;
    logic [31:0] slot_len;
    logic [31:0] win_len;
    logic slot_start;
    logic tick;
    logic cur;
    logic prev;
    logic rise;
    logic fall;
    logic hit;
    logic finish;
    logic start;
    logic [9:0] res;
    logic [7:0] dbl;
    next_s = s;
    access = wb_cyc_i & wb_stb_i & ~s.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wr_word = 32'h0000_0000;
    rd = 32'h0000_0000;
    finish = 1'b0;
    start = 1'b0;
    res = 10'h000;
    dbl = 8'h00;

    // scan slot: one fan per slot, four slots per scan period
    slot_len = s.smart_en ? 32'(SMART_SLOT) : 32'(NORMAL_SLOT);
    win_len = s.smart_en ? 32'(EXT_WINDOW) : 32'(NORMAL_WINDOW);
    slot_start = (s.slot_cnt >= slot_len - 32'h0000_0001);
    next_s.slot_cnt = slot_start ? 32'h0000_0000 : s.slot_cnt + 32'h0000_0001;

    // count timebase: the tach count advances once per tick
    tick = (s.tick_cnt >= 32'(TICK_DIV) - 32'h0000_0001);
    next_s.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;

    // edge detection on the channel being measured; inputs are already synchronous
    next_s.tach_prev = tach_i;
    cur = tach_i[s.ch];
    prev = s.tach_prev[s.ch];
    rise = cur & ~prev;
    fall = ~cur & prev;
    if (s.edge_sel == EDGE_RISE) begin
      hit = rise;
    end else if (s.edge_sel == EDGE_FALL) begin
      hit = fall;
    end else if (s.locked) begin
      hit = s.lock_fall ? fall : rise;
    end else begin
      hit = rise | fall;
    end

    // capture sequencer
    unique case (s.state)
      ST_IDLE: begin
        start = slot_start;
      end
      ST_MEAS: begin
        next_s.win_cnt = s.win_cnt + 32'h0000_0001;
        if (s.edges != 2'h0 && tick && s.cnt != CNT_SAT) begin
          next_s.cnt = s.cnt + 8'h01;
        end
        if (hit) begin
          if (s.edges == 2'h0) begin
            next_s.edges = 2'h1;
            next_s.cnt = 8'h00;
            next_s.locked = 1'b1;
            next_s.lock_fall = fall; // first arriving edge type wins
          end else if (s.edges == 2'h1) begin
            next_s.edges = 2'h2;
            next_s.cnt1 = s.cnt; // single period count kept
          end else begin
            finish = 1'b1;
            res = {s.cnt, s.smart_en ? ACC_TWO : ACC_NORMAL};
          end
        end else if (s.win_cnt >= win_len - 32'h0000_0001) begin
          finish = 1'b1;
          dbl = s.cnt1[7] ? CNT_SAT : {s.cnt1[6:0], 1'b0};
          if (!s.smart_en) begin
            res = {CNT_SAT, ACC_NORMAL};
          end else if (s.edges == 2'h2) begin
            res = {dbl, ACC_ONE}; // doubled single period
          end else begin
            res = {CNT_SAT, ACC_NONE}; // saturated, low accuracy
          end
        end
        if (finish) begin
          next_s.value[s.ch] = res;
          next_s.err[s.ch] = res > s.limit[s.ch]; // period above limit means too slow
          next_s.ext = 1'b0; // back to duty control
          next_s.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (slot_start) begin
          next_s.ch = s.ch + 2'h1;
          start = 1'b1;
        end
      end
    endcase

    // open a capture cycle; in smart mode restart the pwm phase and hold both outputs active
    if (start) begin
      next_s.state = ST_MEAS;
      next_s.win_cnt = 32'h0000_0000;
      next_s.edges = 2'h0;
      next_s.cnt = 8'h00;
      next_s.locked = 1'b0;
      if (s.smart_en) begin
        next_s.ext = 1'b1;
        next_s.pwm_pre = 32'h0000_0000;
        next_s.pwm_cnt = 8'h00;
      end
    end

    // pwm: both outputs share one phase counter so they always start together
    if (!(start && s.smart_en)) begin
      if (s.pwm_pre >= 32'(PWM_PRESCALE) - 32'h0000_0001) begin
        next_s.pwm_pre = 32'h0000_0000;
        next_s.pwm_cnt = s.pwm_cnt + 8'h01;
      end else begin
        next_s.pwm_pre = s.pwm_pre + 32'h0000_0001;
      end
    end
    for (int i = 0; i < 2; i++) begin
      next_s.pwm_q[i] = next_s.ext | (next_s.pwm_cnt < s.duty[i]);
    end

    // wishbone read mux; unmapped offsets read zero and are still acknowledged
    if (wb_adr_i[7:2] == ADR_CTRL[7:2]) begin
      rd[CTRL_SMART_BIT] = s.smart_en;
      rd[CTRL_EDGE_LSB +: 2] = s.edge_sel;
    end else if (wb_adr_i[7:2] == ADR_DUTY[7:2]) begin
      rd[2*DUTY_W-1:0] = s.duty;
    end else if (wb_adr_i[7:2] == ADR_STATUS[7:2]) begin
      rd[STATUS_ERR_LSB +: 4] = s.err;
      rd[STATUS_BUSY_BIT] = (s.state == ST_MEAS);
      rd[STATUS_EXT_BIT] = s.ext;
      rd[STATUS_CH_LSB +: 2] = s.ch;
    end
    for (int i = 0; i < NUM_FANS; i++) begin
      if (wb_adr_i[7:2] == ADR_LIMIT0[7:2] + 6'(i)) begin
        rd[9:0] = s.limit[i];
      end
      if (wb_adr_i[7:2] == ADR_VALUE0[7:2] + 6'(i)) begin
        rd[9:0] = s.value[i];
      end
    end

    // wishbone: one wait state, ack for exactly one cycle, write takes effect with ack
    next_s.ack = access;
    if (access) begin
      next_s.dat = rd;
    end
    if (access && wb_we_i) begin
      wr_word = (rd & ~wmask) | (wb_dat_i & wmask);
      if (wb_adr_i[7:2] == ADR_CTRL[7:2]) begin
        // a mode change takes effect at once, also on the window and result of the capture cycle in progress
        next_s.smart_en = wr_word[CTRL_SMART_BIT];
        next_s.edge_sel = wr_word[CTRL_EDGE_LSB +: 2];
      end else if (wb_adr_i[7:2] == ADR_DUTY[7:2]) begin
        next_s.duty = wr_word[2*DUTY_W-1:0];
      end
      for (int i = 0; i < NUM_FANS; i++) begin
        if (wb_adr_i[7:2] == ADR_LIMIT0[7:2] + 6'(i)) begin
          next_s.limit[i] = wr_word[9:0];
        end
      end
    end

    // synchronous reset overrides everything
    if (rst_i) begin
      next_s = '0;
      next_s.state = ST_IDLE;
      next_s.smart_en = CTRL_SMART_RST;
      next_s.edge_sel = EDGE_RST;
      next_s.duty = {DUTY_RST, DUTY_RST};
      next_s.limit = {LIMIT_RST, LIMIT_RST, LIMIT_RST, LIMIT_RST};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  // every output comes straight from the state register
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign pwm_o = s.pwm_q;
  assign tach_err_o = s.err;

endmodule

// *** src/fan_tach_pkg.sv ***
// constants, register map and state encoding of the smart fan tach capture block
package fan_tach_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing: times in their own unit, window and slot cycle counts derived from the clock rate, tick and pwm prescale given in cycles
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int EXT_WINDOW_MS = 50;
  localparam int SMART_SCAN_MS = 4000;
  localparam int NORMAL_SCAN_MS = 1000;
  localparam int NUM_FANS = 4;
  localparam int EXT_WINDOW_CYC = CLK_PER_MS * EXT_WINDOW_MS;
  localparam int SMART_SLOT_CYC = CLK_PER_MS * SMART_SCAN_MS / NUM_FANS;
  localparam int NORMAL_SLOT_CYC = CLK_PER_MS * NORMAL_SCAN_MS / NUM_FANS;
  localparam int NORMAL_WINDOW_CYC = NORMAL_SLOT_CYC / 2;
  localparam int TICK_DIV_CYC = 52000;
  localparam int PWM_PRESCALE_CYC = 31;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DUTY = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_LIMIT0 = 8'h10;
  localparam logic [7:0] ADR_VALUE0 = 8'h20;

  // field positions
  localparam int CTRL_SMART_BIT = 0;
  localparam int CTRL_EDGE_LSB = 1;
  localparam int DUTY_W = 8;
  localparam int STATUS_ERR_LSB = 0;
  localparam int STATUS_BUSY_BIT = 4;
  localparam int STATUS_EXT_BIT = 5;
  localparam int STATUS_CH_LSB = 6;

  // reset values
  localparam logic CTRL_SMART_RST = 1'b0;
  localparam logic [1:0] EDGE_RST = 2'h3;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [9:0] LIMIT_RST = 10'h3FF;

  // edge select encodings
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  // accuracy codes in the two low value bits, saturated count field
  localparam logic [1:0] ACC_NORMAL = 2'h0;
  localparam logic [1:0] ACC_TWO = 2'h3;
  localparam logic [1:0] ACC_ONE = 2'h2;
  localparam logic [1:0] ACC_NONE = 2'h2;
  localparam logic [7:0] CNT_SAT = 8'hFF;

  // capture sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEAS = 3'b010,
    ST_HOLD = 3'b100
  } seq_state_t;

endpackage

// *** testbench/fan_tach_checker.sv ***
// port assertions for the fan tach capture block
`timescale 1ns/1ps
module fan_tach_checker #(
  parameter int EXT_WINDOW = 2000,
  parameter int PWM_PRESCALE = 2
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic [1:0] pwm_o, // pwm
  input wire logic [3:0] tach_err_o // errors
);
  // slack of one whole duty period, since the phase after an extension is free
  localparam int HI_MAX = EXT_WINDOW + 256 * (PWM_PRESCALE + 1) + 4;
  logic [7:0] adr_q;
  logic we_q;
  int hi_cnt;
  logic mapped;
  // remember the access in flight and time the pwm high phase
  always_ff @(posedge clk_i) begin
    if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      adr_q <= wb_adr_i;
      we_q <= wb_we_i;
    end
    hi_cnt <= (rst_i || !pwm_o[0]) ? 0 : hi_cnt + 1;
  end
  assign mapped = adr_q[7:2] <= 6'h02 || (adr_q[7:2] >= 6'h04 && adr_q[7:2] <= 6'h0B);
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not acked");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_rst_out; $fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0 && tach_err_o == 4'h0 && pwm_o == 2'h0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved between accesses");
  property p_unmapped; wb_ack_o && !mapped && !we_q |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_acc_code; wb_ack_o && adr_q[7:4] == 4'h2 && !we_q |-> wb_dat_o[1:0] != 2'h1 && wb_dat_o[31:10] == 22'h0;
  endproperty
  a_acc_code: assert property (p_acc_code) else $error("bad value format");
  property p_pwm_ext; hi_cnt <= HI_MAX; endproperty
  a_pwm_ext: assert property (p_pwm_ext) else $error("pwm held high too long");
endmodule
bind smart_fan_tach_capture fan_tach_checker #(.EXT_WINDOW(EXT_WINDOW), .PWM_PRESCALE(PWM_PRESCALE)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_o(pwm_o), .tach_err_o(tach_err_o));

// *** testbench/fan_tach_model.sv ***
// behavioural fans whose tach toggles every half period
`timescale 1ns/1ps
module fan_tach_model (
  input wire logic clk_i, // clock
  input wire logic [3:0][15:0] per_i, // period in cycles, 0 stopped
  output logic [3:0] tach_o = 4'h0 // tach lines
);
  int cnt [4];
  // a stopped rotor parks low, like a pulled-down open collector
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= (per_i[i] == 16'h0 || cnt[i] >= per_i[i] / 2 - 1) ? 0 : cnt[i] + 1;
      if (per_i[i] == 16'h0) begin
        tach_o[i] <= 1'b0;
      end else if (cnt[i] >= per_i[i] / 2 - 1) begin
        tach_o[i] <= ~tach_o[i];
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
// self-checking bench of the fan tach capture block
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [3:0] tach;
  logic [3:0] tach_err;
  logic [3:0][15:0] per;
  logic [31:0] q;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 7;
  logic [7:0] ra [7] = '{8'h24, 8'h00, 8'h04, 8'h10, 8'h1C, 8'h20, 8'hFC};
  logic [31:0] rv [7] = '{32'h0, 32'h6, 32'h8080, 32'h3FF, 32'h3FF, 32'h0, 32'h0};
  always #2.5 clk_i = ~clk_i;
  // pwm prescale stays at its default: the pwm phase does not affect measurement
  smart_fan_tach_capture #(.EXT_WINDOW(2000), .SMART_SLOT(5000), .NORMAL_SLOT(4000), .NORMAL_WINDOW(2000),
    .TICK_DIV(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .tach_i(tach), .pwm_o(), .tach_err_o(tach_err));
  fan_tach_model i_fan (.clk_i(clk_i), .per_i(per), .tach_o(tach));
  ////////////////////////////////////////////////////////////////
  task results();
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: the whole run needs about 70k cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end
  // classic single access; the wait is bounded only by the hang guard
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // count field has tol ticks of slack for tick phase
  task chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic ok;
    checks++;
    ok = got[31:10] === exp[31:10] && got[1:0] === exp[1:0] && ^got[9:2] !== 1'bx
      && int'(got[9:2]) + tol >= int'(exp[9:2]) && int'(got[9:2]) <= int'(exp[9:2]) + tol;
    if (!ok) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // reference: two periods of p cycles in 4-cycle ticks
  function logic [31:0] expv(input logic [15:0] p, input logic smart);
    if (p == 16'h0) return smart ? 32'h3FE : 32'h3FC;
    return {22'h0, (p / 2 > 255) ? 8'hFF : 8'(p / 2), smart ? 2'h3 : 2'h0};
  endfunction
  // chosen edge select, then let every channel be measured at least once
  task scan(input logic smart, input logic [1:0] edge_sel, input int slot);
    wb(1'b1, 8'h00, {29'h0, edge_sel, smart});
    repeat (5 * slot) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'h20 + 8'(4 * i), 32'h0);
      chk(q, expv(per[i], smart), 1);
    end
  endtask
  initial begin
    per[0] = 16'(2 * (50 + $unsigned($random(seed)) % 150));
    per[1] = 16'h012C;
    per[2] = 16'h0000;
    per[3] = 16'(2 * (50 + $unsigned($random(seed)) % 150));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h24, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, ra[i], 32'h0);
      chk(q, rv[i], 0);
    end
    // byte lane mask: only the low duty byte is written
    wb_sel <= 4'h1;
    wb(1'b1, 8'h04, 32'h0000_1234);
    wb_sel <= 4'hF;
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h8034, 0);
    scan(1'b0, 2'h3, 4000);
    chk({28'h0, tach_err}, 32'h0, 0);
    scan(1'b1, 2'h1, 5000);
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b1, 8'h10, 32'h10);
    repeat (25000) @(posedge clk_i);
    chk({28'h0, tach_err}, 32'h1, 0);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, expv(per[0], 1'b1), 1);
    results();
  end
endmodule
